// ==== logic/pcfg_regs.sv ====
// pcfg_regs: configuration header registers, window decode and tenure timer
// Function
// - fixed revision code read at byte 08h
// - programming interface byte 09h reads 00h
// - sub-class byte 0Ah reads 00h
// - base-class byte 0Bh reads 02h
// - load timer on FRAME start, count down
// - lost grant: keep bus until count zero
// - counter cleared and held while FRAME idle
// - timer byte read/write, cleared by reset
// - header byte 0Eh reads zero, writes ignored
// - I/O base bits 31-5 read/write
// - claim enabled I/O command on address match
// - I/O base low bits read 00001b
// - memory base bits 31-5 stored, claims matches
// - memory base low bits read zero
// - board vendor code aliases config word
// - board code aliases second config word
// - I/O accesses ignored while disabled
// - memory accesses ignored while disabled
`timescale 1ns/1ps
module pcfg_regs #(
  // arbitrary neutral value; low nibble stands for the silicon step
  parameter logic [7:0] REVISION_CODE = 8'h10
) (
  input wire logic clk_sys, // system clock, 10 MHz
  input wire logic rst_b, // hardware reset, synchronous, active low
  input wire logic clkEn, // clock enable, freezes all state when low
  input wire logic cfgSel, // pulse: configuration data phase for us
  input wire logic cfgWrite, // 1 write, 0 read
  input wire logic [5:0] cfgDwordIdx, // dword number, byte offset bits 7..2
  input wire logic [3:0] cfgByteEn, // byte enables, active high
  input wire logic [31:0] cfgWriteData, // write data
  output logic [31:0] cfgReadData, // read data, held until next read
  output logic cfgReadValid, // pulse: cfgReadData updated
  input wire logic addrPhase, // pulse: address phase on the bus
  input wire logic [31:0] busAddr, // AD[31:0] in the address phase
  input wire logic [3:0] busCmd, // C/BE[3:0] in the address phase
  input wire logic ioAccessEnable, // command register I/O enable
  input wire logic memoryAccessEnable, // command register memory enable
  output logic devselClaim, // pulse: access claimed, drive DEVSEL
  output logic claimIoSpace, // pulse: claim was an I/O access
  output logic claimMemSpace, // pulse: claim was a memory access
  input wire logic [15:0] boardVendorConfigWord, // loaded config word
  input wire logic [15:0] boardCodeConfigWord, // second loaded word
  input wire logic tenureStart, // pulse: own FRAME asserted, tenure begins
  input wire logic frameActive, // level: own FRAME asserted
  input wire logic gntActive, // level: arbiter grant present
  output logic [7:0] tenureCount, // latency counter value
  output logic busRelease // level: tenure over, release the bus
);

  typedef struct packed {
    logic [7:0] tenureTimer;
    logic [26:0] ioWindowAddress;
    logic [26:0] memoryWindowAddress;
    logic [31:0] readData;
    logic readValid;
    logic devsel;
    logic claimIo;
    logic claimMem;
  } pcfg_regs_s;

  pcfg_regs_s st_q;
  pcfg_regs_s st_d;

  // dword number of a byte offset
  function automatic logic [5:0] dwordOf(input logic [7:0] ofs);
    dwordOf = ofs[7:2];
  endfunction : dwordOf

  // byte lane of a byte offset
  function automatic logic [1:0] laneOf(input logic [7:0] ofs);
    laneOf = ofs[1:0];
  endfunction : laneOf

  // merge a write into a 27-bit window address, lane by lane
  function automatic logic [26:0] mergeAddr(
    input logic [26:0] old,
    input logic [31:0] wdata,
    input logic [3:0] be
  );
    logic [31:0] full;
    full = {old, 5'h00};
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        full[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    mergeAddr = full[31:pcfg_pkg::ADDR_LSB];
  endfunction : mergeAddr

  // address-phase command class
  function automatic logic isIoCmd(input logic [3:0] cmd);
    isIoCmd = (cmd == pcfg_pkg::CMD_IO_RD) || (cmd == pcfg_pkg::CMD_IO_WR);
  endfunction : isIoCmd

  function automatic logic isMemCmd(input logic [3:0] cmd);
    case (cmd)
      pcfg_pkg::CMD_MEM_RD,
      pcfg_pkg::CMD_MEM_WR,
      pcfg_pkg::CMD_MEM_RDMULT,
      pcfg_pkg::CMD_MEM_RDLINE,
      pcfg_pkg::CMD_MEM_WRINV: isMemCmd = 1'b1;
      default: isMemCmd = 1'b0;
    endcase
  endfunction : isMemCmd

  // place a byte in its lane of a dword
  function automatic logic [31:0] atLane(input logic [7:0] val, input logic [7:0] ofs);
    atLane = {24'h000000, val} << {laneOf(ofs), 3'b000};
  endfunction : atLane

  // read image of one dword; unmapped dwords and unused lanes read zero
  function automatic logic [31:0] readDword(
    input logic [5:0] idx,
    input pcfg_regs_s s,
    input logic [15:0] vendorWord,
    input logic [15:0] codeWord
  );
    readDword = 32'h00000000;
    if (idx == dwordOf(pcfg_pkg::REV_OFS)) begin
      readDword = atLane(REVISION_CODE, pcfg_pkg::REV_OFS)
                | atLane(pcfg_pkg::PROGIF_VAL, pcfg_pkg::PROGIF_OFS)
                | atLane(pcfg_pkg::SUBCLASS_VAL, pcfg_pkg::SUBCLASS_OFS)
                | atLane(pcfg_pkg::BASECLASS_VAL, pcfg_pkg::BASECLASS_OFS);
    end else if (idx == dwordOf(pcfg_pkg::TENURE_OFS)) begin
      readDword = atLane(s.tenureTimer, pcfg_pkg::TENURE_OFS)
                | atLane(pcfg_pkg::HDR_VAL, pcfg_pkg::HDR_OFS);
    end else if (idx == dwordOf(pcfg_pkg::IO_WINDOW_OFS)) begin
      readDword = {s.ioWindowAddress, pcfg_pkg::IO_LOW_BITS};
    end else if (idx == dwordOf(pcfg_pkg::MEM_WINDOW_OFS)) begin
      readDword = {s.memoryWindowAddress, pcfg_pkg::MEM_LOW_BITS};
    end else if (idx == dwordOf(pcfg_pkg::BVENDOR_OFS)) begin
      readDword[laneOf(pcfg_pkg::BVENDOR_OFS)*8 +: 16] = vendorWord;
      readDword[laneOf(pcfg_pkg::BCODE_OFS)*8 +: 16] = codeWord;
    end
  endfunction : readDword

  logic writeHit;
  logic readHit;
  logic ioMatch;
  logic memMatch;
  logic [1:0] tenureLane;

  always_comb begin
    st_d = st_q;
    writeHit = cfgSel && cfgWrite;
    readHit = cfgSel && !cfgWrite;
    tenureLane = laneOf(pcfg_pkg::TENURE_OFS);

    // configuration writes; fixed fields simply have no storage
    if (writeHit) begin
      if (cfgDwordIdx == dwordOf(pcfg_pkg::TENURE_OFS) && cfgByteEn[tenureLane]) begin
        st_d.tenureTimer = cfgWriteData[tenureLane*8 +: 8];
      end
      if (cfgDwordIdx == dwordOf(pcfg_pkg::IO_WINDOW_OFS)) begin
        st_d.ioWindowAddress = mergeAddr(st_q.ioWindowAddress, cfgWriteData, cfgByteEn);
      end
      if (cfgDwordIdx == dwordOf(pcfg_pkg::MEM_WINDOW_OFS)) begin
        st_d.memoryWindowAddress = mergeAddr(st_q.memoryWindowAddress, cfgWriteData, cfgByteEn);
      end
    end

    // read data holds between reads so a slow data phase can sample it
    st_d.readValid = readHit;
    if (readHit) begin
      st_d.readData = readDword(cfgDwordIdx, st_q, boardVendorConfigWord, boardCodeConfigWord);
    end

    // address decode: a disabled space never claims, whatever the base holds
    ioMatch = addrPhase && ioAccessEnable && isIoCmd(busCmd)
           && (busAddr[31:pcfg_pkg::ADDR_LSB] == st_q.ioWindowAddress);
    memMatch = addrPhase && memoryAccessEnable && isMemCmd(busCmd)
            && (busAddr[31:pcfg_pkg::ADDR_LSB] == st_q.memoryWindowAddress);
    st_d.claimIo = ioMatch;
    st_d.claimMem = memMatch;
    st_d.devsel = ioMatch || memMatch;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_q.tenureTimer <= pcfg_pkg::TENURE_RST;
      st_q.ioWindowAddress <= pcfg_pkg::WINDOW_RST;
      st_q.memoryWindowAddress <= pcfg_pkg::WINDOW_RST;
      st_q.readData <= 32'h00000000;
      st_q.readValid <= 1'b0;
      st_q.devsel <= 1'b0;
      st_q.claimIo <= 1'b0;
      st_q.claimMem <= 1'b0;
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end

  assign cfgReadData = st_q.readData;
  assign cfgReadValid = st_q.readValid;
  assign devselClaim = st_q.devsel;
  assign claimIoSpace = st_q.claimIo;
  assign claimMemSpace = st_q.claimMem;

  // counter kept apart: it runs on master activity, not on config cycles
  pcfg_tenure u_tenure (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .timerValue(st_q.tenureTimer),
    .tenureStart(tenureStart),
    .frameActive(frameActive),
    .gntActive(gntActive),
    .tenureCount(tenureCount),
    .busRelease(busRelease)
  );

endmodule : pcfg_regs

// ==== logic/pcfg_tenure.sv ====
// pcfg_tenure: master bus tenure countdown driven by the latency timer value
`timescale 1ns/1ps
module pcfg_tenure (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic clkEn, // clock enable, freezes state when low
  input wire logic [7:0] timerValue, // programmed tenure timer
  input wire logic tenureStart, // pulse: own FRAME asserted at start of tenure
  input wire logic frameActive, // level: own FRAME asserted
  input wire logic gntActive, // level: grant from arbiter present
  output logic [7:0] tenureCount, // current counter value
  output logic busRelease // level: bus must be released now
);

  typedef struct packed {
    logic [7:0] count;
    logic release_;
  } pcfg_tenure_s;

  pcfg_tenure_s st_q;
  pcfg_tenure_s st_d;

  always_comb begin
    st_d = st_q;
    if (!frameActive) begin
      // idle between tenures: counter held cleared
      st_d.count = 8'h00;
    end else if (tenureStart) begin
      st_d.count = timerValue;
    end else if (st_q.count != 8'h00) begin
      st_d.count = st_q.count - 8'h01;
    end
    // grant loss is honoured only once the count has run out
    st_d.release_ = frameActive && !gntActive && (st_d.count == 8'h00);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_q <= '0;
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end

  assign tenureCount = st_q.count;
  assign busRelease = st_q.release_;

endmodule : pcfg_tenure

// ==== pkg/pcfg_pkg.sv ====
// pcfg_pkg: offsets, fixed values and bus commands of the configuration header block
package pcfg_pkg;

  // configuration byte offsets
  localparam logic [7:0] REV_OFS = 8'h08;
  localparam logic [7:0] PROGIF_OFS = 8'h09;
  localparam logic [7:0] SUBCLASS_OFS = 8'h0a;
  localparam logic [7:0] BASECLASS_OFS = 8'h0b;
  localparam logic [7:0] TENURE_OFS = 8'h0d;
  localparam logic [7:0] HDR_OFS = 8'h0e;
  localparam logic [7:0] IO_WINDOW_OFS = 8'h10;
  localparam logic [7:0] MEM_WINDOW_OFS = 8'h14;
  localparam logic [7:0] BVENDOR_OFS = 8'h2c;
  localparam logic [7:0] BCODE_OFS = 8'h2e;

  // fixed read-only contents
  localparam logic [7:0] PROGIF_VAL = 8'h00;
  localparam logic [7:0] SUBCLASS_VAL = 8'h00;
  localparam logic [7:0] BASECLASS_VAL = 8'h02;
  localparam logic [7:0] HDR_VAL = 8'h00;

  // window address field: bits 31..5 are stored, 4..0 are fixed
  localparam int ADDR_LSB = 5;
  localparam logic [4:0] IO_LOW_BITS = 5'h01;
  localparam logic [4:0] MEM_LOW_BITS = 5'h00;

  // reset values
  localparam logic [7:0] TENURE_RST = 8'h00;
  localparam logic [26:0] WINDOW_RST = 27'h0000000;

  // bus commands on C/BE[3:0] during the address phase
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_MEM_RDMULT = 4'hc;
  localparam logic [3:0] CMD_MEM_RDLINE = 4'he;
  localparam logic [3:0] CMD_MEM_WRINV = 4'hf;

endpackage : pcfg_pkg

// ==== verification/pcfg_arb_model.sv ====
// pcfg_arb_model: arbiter and frame driver around one bus tenure
`timescale 1ns/1ps
module pcfg_arb_model (
  input wire logic clk_sys, // clock
  input wire logic go, // request one tenure
  input wire logic [7:0] gntLen, // grant is kept gntLen + 1 cycles
  input wire logic busRelease, // device gives up the bus
  output logic tenureStart = 1'b0, // frame begins
  output logic frameActive = 1'b0, // frame level
  output logic gntActive = 1'b0 // grant level
);
  logic [7:0] left = 8'h00;
  // drives on the falling edge so the device samples settled levels
  always @(negedge clk_sys) begin
    tenureStart <= go & ~frameActive;
    if (go & ~frameActive) begin
      frameActive <= 1'b1;
      gntActive <= 1'b1;
      left <= gntLen;
    end else if (frameActive) begin
      if (left != 8'h00)
        left <= left - 8'h01;
      else
        gntActive <= 1'b0;
      if (busRelease)
        frameActive <= 1'b0;
    end
  end
endmodule : pcfg_arb_model

// ==== verification/pcfg_regs_asserts.sv ====
// pcfg_regs_asserts: port-level checks of the configuration header block
`timescale 1ns/1ps
module pcfg_regs_asserts #(
  parameter logic [7:0] REVISION_CODE = 8'h10
) (
  input wire logic clk_sys, // clock
  input wire logic rst_b, // reset
  input wire logic clkEn, // enable
  input wire logic cfgSel, // config strobe
  input wire logic cfgWrite, // write flag
  input wire logic [5:0] cfgDwordIdx, // dword
  input wire logic [31:0] cfgReadData, // read data
  input wire logic cfgReadValid, // read answer
  input wire logic addrPhase, // address strobe
  input wire logic ioAccessEnable, // io enable
  input wire logic memoryAccessEnable, // mem enable
  input wire logic devselClaim, // claim
  input wire logic claimIoSpace, // io claim
  input wire logic claimMemSpace, // mem claim
  input wire logic tenureStart, // tenure begin
  input wire logic frameActive, // frame level
  input wire logic gntActive, // grant level
  input wire logic [7:0] tenureCount, // counter
  input wire logic busRelease // release
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire rdTake = clkEn & cfgSel & ~cfgWrite;
  read_answer_a: assert property (rdTake |=> cfgReadValid)
    else $error("read not answered");
  id_word_a: assert property (rdTake && cfgDwordIdx == 6'h02 |=> cfgReadData == {8'h02, 8'h00, 8'h00, REVISION_CODE})
    else $error("class word wrong");
  header_zero_a: assert property (rdTake && cfgDwordIdx == 6'h03 |=> cfgReadData[23:16] == 8'h00)
    else $error("header byte not zero");
  io_off_a: assert property (clkEn && addrPhase && !ioAccessEnable |=> !claimIoSpace)
    else $error("io claim while disabled");
  mem_off_a: assert property (clkEn && addrPhase && !memoryAccessEnable |=> !claimMemSpace)
    else $error("mem claim while disabled");
  claim_tie_a: assert property (claimIoSpace || claimMemSpace |-> devselClaim && $past(addrPhase))
    else $error("claim without address phase");
  idle_clear_a: assert property (clkEn && !frameActive |=> tenureCount == 8'h00)
    else $error("counter not cleared");
  count_down_a: assert property (clkEn && frameActive && !tenureStart |=>
    tenureCount == ($past(tenureCount) == 8'h00 ? 8'h00 : $past(tenureCount) - 8'h01))
    else $error("counter step wrong");
  grant_keep_a: assert property (clkEn && gntActive |=> !busRelease)
    else $error("release while granted");
  release_zero_a: assert property (busRelease |-> tenureCount == 8'h00)
    else $error("release with count left");
endmodule : pcfg_regs_asserts

bind pcfg_regs pcfg_regs_asserts #(.REVISION_CODE(REVISION_CODE)) chk_u (.clk_sys, .rst_b, .clkEn, .cfgSel,
  .cfgWrite, .cfgDwordIdx, .cfgReadData, .cfgReadValid, .addrPhase, .ioAccessEnable, .memoryAccessEnable,
  .devselClaim, .claimIoSpace, .claimMemSpace, .tenureStart, .frameActive, .gntActive, .tenureCount, .busRelease);

// ==== verification/tb_pcfg_regs.sv ====
// tb_pcfg_regs: random and corner tests of the configuration header block
`timescale 1ns/1ps
module tb_pcfg_regs;
  logic clk_sys = 1'b0, rst_b = 1'b0, clkEn = 1'b1, cfgSel = 1'b0, cfgWrite = 1'b0, addrPhase = 1'b0;
  logic ioAccessEnable = 1'b0, memoryAccessEnable = 1'b0, go = 1'b0;
  logic [5:0] cfgDwordIdx = 6'h00;
  logic [3:0] cfgByteEn = 4'h0, busCmd = 4'h0;
  logic [31:0] cfgWriteData = 32'h0, busAddr = 32'h0, d, ioReg = 32'h1, memReg = 32'h0;
  logic [15:0] boardVendorConfigWord = 16'h0, boardCodeConfigWord = 16'h0;
  logic [7:0] gntLen = 8'h00, tenureCount;
  logic [31:0] cfgReadData;
  logic cfgReadValid, devselClaim, claimIoSpace, claimMemSpace, tenureStart, frameActive, gntActive, busRelease;
  int miscompares = 0, check_count = 0;
  always #50 clk_sys = ~clk_sys;
  pcfg_regs #(.REVISION_CODE(8'h10)) dut_u (.clk_sys, .rst_b, .clkEn, .cfgSel, .cfgWrite, .cfgDwordIdx,
    .cfgByteEn, .cfgWriteData, .cfgReadData, .cfgReadValid, .addrPhase, .busAddr, .busCmd, .ioAccessEnable,
    .memoryAccessEnable, .devselClaim, .claimIoSpace, .claimMemSpace, .boardVendorConfigWord,
    .boardCodeConfigWord, .tenureStart, .frameActive, .gntActive, .tenureCount, .busRelease);
  pcfg_arb_model arb_u (.clk_sys, .go, .gntLen, .busRelease, .tenureStart, .frameActive, .gntActive);
  task automatic summarize();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [5:0] i, input logic [3:0] be, input logic [31:0] v);
    @(negedge clk_sys);
    {cfgSel, cfgWrite, cfgDwordIdx, cfgByteEn, cfgWriteData} = {1'b1, w, i, be, v};
    @(negedge clk_sys);
    cfgSel = 1'b0;
    d = cfgReadData;
  endtask : acc
  task automatic rchk(input logic [5:0] i, input logic [31:0] exp);
    acc(1'b0, i, 4'h0, 32'h0);
    chk(32'(cfgReadValid), 32'h1);
    chk(d, exp);
  endtask : rchk
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v, input logic [3:0] be);
    for (int b = 0; b < 4; b++)
      if (be[b])
        o[8*b +: 8] = v[8*b +: 8];
    return o;
  endfunction : merge
  function automatic logic [2:0] claimExp(input logic [3:0] c, input logic [31:0] a);
    logic io, mem;
    io = ioAccessEnable && c[3:1] == 3'h1 && a[31:5] == ioReg[31:5];
    mem = memoryAccessEnable && c inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf} && a[31:5] == memReg[31:5];
    return {io | mem, io, mem};
  endfunction : claimExp
  task automatic tenure(input logic [7:0] t, input logic [7:0] g);
    int k;
    acc(1'b1, 6'h03, 4'h2, {16'h0, t, 8'h0});
    rchk(6'h03, {16'h0, t, 8'h0});
    gntLen = g;
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    k = 1;
    #1;
    while (busRelease !== 1'b1 && k < 300) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk(32'(k), (int'(t) + 1 > int'(g) + 2) ? int'(t) + 1 : int'(g) + 2);
    if (k >= 300)
      summarize();
    repeat (3) @(negedge clk_sys);
    chk(32'(tenureCount), 32'h0);
  endtask : tenure
  initial begin
    logic [31:0] v, a;
    logic [3:0] be;
    v = $urandom(32'hc8b33267);
    {boardCodeConfigWord, boardVendorConfigWord} = $urandom;
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
    rchk(6'h02, {8'h02, 8'h00, 8'h00, 8'h10});
    rchk(6'h03, 32'h0);
    rchk(6'h04, 32'h1);
    rchk(6'h05, 32'h0);
    rchk(6'h0b, {boardCodeConfigWord, boardVendorConfigWord});
    rchk(6'h14, 32'h0);
    $display("test reset values done");
    for (int i = 2; i < 6; i++)
      acc(1'b1, 6'(i), 4'hf, 32'hffffffff);
    rchk(6'h02, {8'h02, 8'h00, 8'h00, 8'h10});
    rchk(6'h03, 32'h0000ff00);
    rchk(6'h04, 32'hffffffe1);
    rchk(6'h05, 32'hffffffe0);
    rst_b = 1'b0;
    @(negedge clk_sys);
    rst_b = 1'b1;
    rchk(6'h04, 32'h1);
    rchk(6'h03, 32'h0);
    $display("test size probe done");
    repeat (20) begin
      v = $urandom;
      be = 4'($urandom);
      acc(1'b1, 6'h04, be, v);
      ioReg = merge(ioReg, v, be) & 32'hffffffe0 | 32'h1;
      rchk(6'h04, ioReg);
      acc(1'b1, 6'h05, be, ~v);
      memReg = merge(memReg, ~v, be) & 32'hffffffe0;
      rchk(6'h05, memReg);
    end
    $display("test byte lanes done");
    // bases were programmed above, only now are the enables raised
    repeat (80) begin
      v = $urandom;
      a = $urandom;
      if (v[0])
        a[31:5] = ioReg[31:5];
      else if (v[1])
        a[31:5] = memReg[31:5];
      {ioAccessEnable, memoryAccessEnable} = v[3:2];
      @(negedge clk_sys);
      {addrPhase, busAddr, busCmd} = {1'b1, a, v[7:4]};
      @(negedge clk_sys);
      addrPhase = 1'b0;
      chk(32'({devselClaim, claimIoSpace, claimMemSpace}), 32'(claimExp(v[7:4], a)));
    end
    $display("test decode done");
    // a write taken while the enable is low must leave the timer alone
    clkEn = 1'b0;
    acc(1'b1, 6'h03, 4'hf, 32'hffffffff);
    clkEn = 1'b1;
    rchk(6'h03, 32'h0);
    $display("test clock enable done");
    tenure(8'h05, 8'h01);
    tenure(8'h02, 8'h06);
    tenure(8'h00, 8'h00);
    repeat (5)
      tenure(8'($urandom_range(20)), 8'($urandom_range(20)));
    $display("test tenure done");
    summarize();
  end
endmodule : tb_pcfg_regs
